// File: rtl/cim_defs.svh
// register offsets, field positions and reset values of the charger interrupt mask block
// assumes: included by the package and design files by bare name
`ifndef CIM_DEFS_SVH
`define CIM_DEFS_SVH

`define CIM_ADDR_W 8
`define CIM_OFS_CHG_MASK 8'h2a
`define CIM_OFS_THERM_MASK 8'h2b
`define CIM_OFS_FAULT_MASK 8'h2c
`define CIM_RST_VAL 8'h00
// writable bits of each register, reserved bits stay zero
`define CIM_CHG_WMASK 8'h7f
`define CIM_THERM_WMASK 8'h1f
`define CIM_FAULT_WMASK 8'hff
// field positions in the charger event mask
`define CIM_BIT_SRC_DET 6
`define CIM_BIT_ADC_DONE 5
`define CIM_BIT_MIN_SYS 4
`define CIM_BIT_FAST_TMR 3
`define CIM_BIT_TRICKLE_TMR 2
`define CIM_BIT_PRE_TMR 1
`define CIM_BIT_TOPOFF_TMR 0
// field positions in the thermal and boost mask
`define CIM_BIT_BAT_LOW_BOOST 4
`define CIM_BIT_COLD 3
`define CIM_BIT_COOL 2
`define CIM_BIT_WARM 1
`define CIM_BIT_HOT 0
// number of maskable event lines: 7 + 5 + 8
`define CIM_NUM_EV 20

`endif

// File: rtl/cim_pkg.sv
// types shared by the charger interrupt mask block
// assumes: cim_defs.svh supplies the numbers
`include "cim_defs.svh"
package cim_pkg;
    typedef logic [7:0] cim_byte_t;
    typedef logic [`CIM_NUM_EV-1:0] cim_ev_t;
    typedef struct packed {
        cim_byte_t chg_mask;
        cim_byte_t therm_mask;
        cim_byte_t fault_mask;
        cim_byte_t rdata;
        logic rvalid;
        cim_ev_t flags;
        logic irq;
    } cim_state_t;
endpackage : cim_pkg

// File: rtl/cim_mask_reg.sv
// one 8-bit mask register with separate clear sources
// assumes: single clock, writes are one-cycle strobes
`timescale 1ns/10ps
`include "cim_defs.svh"
module cim_mask_reg #(
    parameter logic [7:0] WMASK = 8'hff,
    parameter logic [7:0] WDOG_CLR = 8'h00
) (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    input wire logic i_reg_rst,
    input wire logic i_wdog,
    output logic [7:0] o_val
);
    typedef struct packed {
        logic [7:0] val;
    } cim_mr_state_t;
    cim_mr_state_t s_q;
    cim_mr_state_t s_d;

    ////////////////////////////////////////////////////////////////
    // clears win over a same-cycle write; reserved bits forced zero
    always_comb begin
        s_d = s_q;
        if (i_wr) begin
            s_d.val = i_wdata & WMASK;
        end
        if (i_wdog) begin
            s_d.val = s_d.val & ~WDOG_CLR;
        end
        if (i_reg_rst) begin
            s_d.val = `CIM_RST_VAL;
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_q <= '0;
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end

    assign o_val = s_q.val;
endmodule : cim_mask_reg

// File: rtl/cim_top.sv
// charger interrupt mask registers with flag capture and interrupt pulse
// assumes: host register port already decoded to byte address and strobes
// assumes: event inputs are one-cycle pulses already in this clock domain
// How it works
// - mask bit zero lets its event pulse the interrupt, one blocks it.
// - all three mask registers reset to zero.
// - charger mask bit 6 gates data-line source detection done.
// - charger mask bit 5 gates single-conversion converter done.
// - charger mask bit 4 gates entry or exit of minimum-system regulation.
// - charger mask bits 3..0 gate fast, trickle, pre-charge, top-off timer expiry.
// - thermal mask bit 4 gates battery too low for boost; watchdog clears.
// - thermal mask bits 3..0 gate cold, cool, warm, hot crossings; watchdog clears.
// - fault mask bit 7 gates battery-current regulation entry and exit.
// - fault mask bit 6 gates bus over-voltage entry.
// - fault mask bit 5 gates battery over-voltage entry.
// - fault mask bit 4 gates input over-current fault.
// - fault mask bit 3 gates battery over-current fault.
// - fault mask bit 2 gates switch over-current fault.
// - fault mask bits 1 and 0 gate adapter b and a over-voltage.
// - register-reset command clears every writable mask bit.
`timescale 1ns/10ps
`include "cim_defs.svh"
module cim_top (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire logic [7:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_wdata,
    input wire logic i_reg_rst,
    input wire logic i_wdog_expire,
    input wire logic i_src_detect_done,
    input wire logic i_adc_done,
    input wire logic i_adc_one_shot,
    input wire logic i_min_sys_change,
    input wire logic i_fast_tmr_expire,
    input wire logic i_trickle_tmr_expire,
    input wire logic i_pre_tmr_expire,
    input wire logic i_topoff_tmr_expire,
    input wire logic i_bat_low_boost,
    input wire logic i_therm_cold,
    input wire logic i_therm_cool,
    input wire logic i_therm_warm,
    input wire logic i_therm_hot,
    input wire logic i_bat_cur_reg_change,
    input wire logic i_bus_ovp,
    input wire logic i_bat_ovp,
    input wire logic i_input_ocp,
    input wire logic i_bat_ocp,
    input wire logic i_switch_ocp,
    input wire logic i_adapter_b_ovp,
    input wire logic i_adapter_a_ovp,
    input wire logic i_flag_clr,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    output logic [`CIM_NUM_EV-1:0] o_event_flags,
    output logic o_irq_pulse,
    output logic [7:0] o_chg_mask,
    output logic [7:0] o_therm_mask,
    output logic [7:0] o_fault_mask
);
    cim_pkg::cim_state_t s_q;
    cim_pkg::cim_state_t s_d;
    logic [7:0] chg_val;
    logic [7:0] therm_val;
    logic [7:0] fault_val;
    logic wr_chg;
    logic wr_therm;
    logic wr_fault;
    cim_pkg::cim_ev_t ev;
    cim_pkg::cim_ev_t blk;

    ////////////////////////////////////////////////////////////////
    // address decode for the three writable registers
    assign wr_chg = i_wr && (i_addr == `CIM_OFS_CHG_MASK);
    assign wr_therm = i_wr && (i_addr == `CIM_OFS_THERM_MASK);
    assign wr_fault = i_wr && (i_addr == `CIM_OFS_FAULT_MASK);

    // reserved bits are cut by the write masks
    cim_mask_reg #(.WMASK(`CIM_CHG_WMASK), .WDOG_CLR(8'h00)) u_chg (
        .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_ce(i_ce), .i_wr(wr_chg),
        .i_wdata(i_wdata), .i_reg_rst(i_reg_rst), .i_wdog(i_wdog_expire),
        .o_val(chg_val)
    );
    // watchdog also clears the boost and thermal fields
    cim_mask_reg #(.WMASK(`CIM_THERM_WMASK), .WDOG_CLR(`CIM_THERM_WMASK)) u_therm (
        .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_ce(i_ce), .i_wr(wr_therm),
        .i_wdata(i_wdata), .i_reg_rst(i_reg_rst), .i_wdog(i_wdog_expire),
        .o_val(therm_val)
    );
    cim_mask_reg #(.WMASK(`CIM_FAULT_WMASK), .WDOG_CLR(8'h00)) u_fault (
        .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_ce(i_ce), .i_wr(wr_fault),
        .i_wdata(i_wdata), .i_reg_rst(i_reg_rst), .i_wdog(i_wdog_expire),
        .o_val(fault_val)
    );

    // write path checks: reserved bits never land when no clear comes in the same cycle
    a_chg_write_cut: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && wr_chg && !i_reg_rst |=> chg_val == ($past(i_wdata) & `CIM_CHG_WMASK))
        else $error("charger mask write kept reserved bits");
    a_therm_write_cut: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && wr_therm && !i_reg_rst && !i_wdog_expire |=> therm_val == ($past(i_wdata) & `CIM_THERM_WMASK))
        else $error("thermal mask write kept reserved bits");
    // watchdog touches only the thermal and boost fields
    a_wdog_spares_chg: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_wdog_expire && !i_reg_rst && !wr_chg |=> $stable(chg_val))
        else $error("watchdog disturbed charger mask");
    // writes to unmapped offsets move no mask
    a_unmapped_write: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_wr && !wr_chg && !wr_therm && !wr_fault && !i_reg_rst && !i_wdog_expire
        |=> $stable(chg_val) && $stable(therm_val) && $stable(fault_val))
        else $error("unmapped write changed a mask");
    // a frozen clock enable holds every mask bit
    a_ce_holds_masks: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        !i_ce |=> $stable(chg_val) && $stable(therm_val) && $stable(fault_val))
        else $error("mask changed while clock enable low");

    ////////////////////////////////////////////////////////////////
    // event vector: fault mask in bits 19..12, thermal 11..7, charger 6..0
    always_comb begin
        ev = '0;
        ev[6] = i_src_detect_done;
        ev[5] = i_adc_done & i_adc_one_shot; // continuous mode never interrupts
        ev[4] = i_min_sys_change;
        ev[3] = i_fast_tmr_expire;
        ev[2] = i_trickle_tmr_expire;
        ev[1] = i_pre_tmr_expire;
        ev[0] = i_topoff_tmr_expire;
        ev[11] = i_bat_low_boost;
        ev[10] = i_therm_cold;
        ev[9] = i_therm_cool;
        ev[8] = i_therm_warm;
        ev[7] = i_therm_hot;
        ev[19] = i_bat_cur_reg_change;
        ev[18] = i_bus_ovp;
        ev[17] = i_bat_ovp;
        ev[16] = i_input_ocp;
        ev[15] = i_bat_ocp;
        ev[14] = i_switch_ocp;
        ev[13] = i_adapter_b_ovp;
        ev[12] = i_adapter_a_ovp;
    end

    // one mask bit per event line, same layout as ev
    assign blk = {fault_val, therm_val[4:0], chg_val[6:0]};

    // per-line gates: an open mask bit lets its event through one cycle later
    a_adc_one_shot: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_adc_done && i_adc_one_shot && !chg_val[5] |=> o_irq_pulse)
        else $error("one-shot conversion done did not interrupt");
    a_min_sys_gate: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_min_sys_change && !chg_val[4] |=> o_irq_pulse)
        else $error("minimum-system change did not interrupt");
    a_topoff_gate: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_topoff_tmr_expire && !chg_val[0] |=> o_irq_pulse)
        else $error("top-off timer did not interrupt");
    a_boost_low_gate: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_bat_low_boost && !therm_val[4] |=> o_irq_pulse)
        else $error("battery low for boost did not interrupt");
    a_therm_hot_gate: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_therm_hot && !therm_val[0] |=> o_irq_pulse)
        else $error("hot crossing did not interrupt");
    a_cur_reg_gate: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_bat_cur_reg_change && !fault_val[7] |=> o_irq_pulse)
        else $error("battery current regulation did not interrupt");
    a_bat_ovp_gate: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_bat_ovp && !fault_val[5] |=> o_irq_pulse)
        else $error("battery over-voltage did not interrupt");
    a_input_ocp_gate: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_input_ocp && !fault_val[4] |=> o_irq_pulse)
        else $error("input over-current did not interrupt");
    a_bat_ocp_gate: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_bat_ocp && !fault_val[3] |=> o_irq_pulse)
        else $error("battery over-current did not interrupt");
    a_switch_ocp_gate: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_switch_ocp && !fault_val[2] |=> o_irq_pulse)
        else $error("switch over-current did not interrupt");
    a_adapter_b_gate: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_adapter_b_ovp && !fault_val[1] |=> o_irq_pulse)
        else $error("adapter b over-voltage did not interrupt");
    a_adapter_a_gate: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_adapter_a_ovp && !fault_val[0] |=> o_irq_pulse)
        else $error("adapter a over-voltage did not interrupt");
    // a set mask bit on every active line keeps the pulse low
    a_masked_all_quiet: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && ((ev & ~blk) == '0) |=> !o_irq_pulse)
        else $error("pulse with every active line masked");

    ////////////////////////////////////////////////////////////////
    // next state: read port, sticky flags, gated pulse
    always_comb begin
        s_d = s_q;
        s_d.chg_mask = chg_val;
        s_d.therm_mask = therm_val;
        s_d.fault_mask = fault_val;
        s_d.rvalid = i_rd;
        if (i_rd) begin
            unique case (i_addr)
                `CIM_OFS_CHG_MASK: s_d.rdata = chg_val; // bit 7 reads zero
                `CIM_OFS_THERM_MASK: s_d.rdata = therm_val;
                `CIM_OFS_FAULT_MASK: s_d.rdata = fault_val;
                default: s_d.rdata = 8'h00; // unmapped reads zero
            endcase
        end
        // flags record regardless of mask; set wins over clear
        if (i_flag_clr) begin
            s_d.flags = '0;
        end
        s_d.flags = s_d.flags | ev;
        s_d.irq = |(ev & ~blk); // zero in a mask lets the pulse through
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_q <= '0;
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end

    // read port and flag checks, one cycle behind the strobe or event
    a_rvalid_follows: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce |=> o_rvalid == $past(i_rd))
        else $error("read valid not one cycle behind strobe");
    a_read_chg: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_rd && i_addr == `CIM_OFS_CHG_MASK |=> o_rdata == $past(chg_val))
        else $error("charger mask read back wrong");
    a_read_therm: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_rd && i_addr == `CIM_OFS_THERM_MASK |=> o_rdata == $past(therm_val))
        else $error("thermal mask read back wrong");
    a_read_fault: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_rd && i_addr == `CIM_OFS_FAULT_MASK |=> o_rdata == $past(fault_val))
        else $error("fault mask read back wrong");
    a_read_unmapped: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_rd && i_addr != `CIM_OFS_CHG_MASK && i_addr != `CIM_OFS_THERM_MASK
        && i_addr != `CIM_OFS_FAULT_MASK |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_flag_set_wins: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_flag_clr && i_bus_ovp |=> o_event_flags[18])
        else $error("flag clear beat a same-cycle event");
    a_flag_sticky: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && !i_flag_clr |=> (o_event_flags & $past(o_event_flags)) == $past(o_event_flags))
        else $error("event flag dropped without a clear");
    a_flag_clears: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_flag_clr && ev == '0 |=> o_event_flags == '0)
        else $error("flag clear left flags set");
    a_mask_mirror: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce |=> o_chg_mask == $past(chg_val) && o_therm_mask == $past(therm_val)
        && o_fault_mask == $past(fault_val))
        else $error("mask mirror outputs out of step");
    a_ce_holds_state: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        !i_ce |=> $stable(s_q))
        else $error("state moved while clock enable low");

    assign o_rdata = s_q.rdata;
    assign o_rvalid = s_q.rvalid;
    assign o_event_flags = s_q.flags;
    assign o_irq_pulse = s_q.irq;
    assign o_chg_mask = s_q.chg_mask;
    assign o_therm_mask = s_q.therm_mask;
    assign o_fault_mask = s_q.fault_mask;

    ////////////////////////////////////////////////////////////////
    // checks
    // gate checks; the masked and continuous-mode antecedents leave the other lines quiet
    a_masked_no_irq: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_fast_tmr_expire && chg_val[3] && ((ev & ~blk) == '0) |=> !o_irq_pulse)
        else $error("masked timer event raised interrupt");
    a_open_irq: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_bus_ovp && !fault_val[6] |=> o_irq_pulse)
        else $error("unmasked bus ovp missed interrupt");
    a_src_det_gate: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_src_detect_done && !chg_val[6] |=> o_irq_pulse)
        else $error("source detect did not interrupt");
    a_adc_cont_quiet: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_adc_done && !i_adc_one_shot && ((ev & ~blk) == '0) |=> !o_irq_pulse)
        else $error("continuous conversion raised interrupt");
    // reserved bits are never stored, so they can only read zero
    a_reserved_zero: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        chg_val[7] == 1'b0 && therm_val[7:5] == 3'h0)
        else $error("reserved mask bits not zero");
    // clear commands; a same-cycle fault write or register reset may still move the fault mask
    a_wdog_clears: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_wdog_expire && !wr_fault && !i_reg_rst |=> therm_val == 8'h00 && $stable(fault_val))
        else $error("watchdog clear wrong");
    a_regrst_clears: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_reg_rst |=> chg_val == 8'h00 && therm_val == 8'h00 && fault_val == 8'h00)
        else $error("register reset left mask bits");
    a_flag_records: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_bat_ocp |=> o_event_flags[15])
        else $error("event flag lost while masked");
    a_write_lands: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && wr_fault && !i_reg_rst |=> fault_val == $past(i_wdata))
        else $error("fault mask write lost");
    // main scenarios worth seeing at least once
    c_masked_event: cover property (@(posedge i_mclk) i_bat_ocp && fault_val[3]);
    c_open_event: cover property (@(posedge i_mclk) o_irq_pulse);
    c_wdog: cover property (@(posedge i_mclk) i_wdog_expire && therm_val != 8'h00);
    c_flag_race: cover property (@(posedge i_mclk) i_flag_clr && i_bus_ovp);
    c_ce_frozen_write: cover property (@(posedge i_mclk) !i_ce && i_wr);
endmodule : cim_top

// File: dv/cim_host_model.sv
// host side of the mask block: register port master with read-back
// assumes: tasks are entered just after a falling clock edge
`timescale 1ns/10ps
module cim_host_model (
    input wire logic i_mclk,
    input wire logic i_rvalid,
    input wire logic [7:0] i_rdata,
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata
);
    // idle bus at time zero
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
    end

    ////////////////////////////////////////////////////////////////
    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(negedge i_mclk);
        o_wr = 1'b0;
        o_wdata = ~d; // released data shows junk, so stale values cannot help
        @(negedge i_mclk); // idle cycle: a following call never re-raises the strobe in this step
    endtask : wr

    // read strobe; data and valid stand one cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        o_addr = a;
        o_rd = 1'b1;
        @(negedge i_mclk);
        o_rd = 1'b0;
        v = i_rvalid;
        d = i_rdata;
        @(negedge i_mclk); // idle cycle before the next strobe
    endtask : rd
endmodule : cim_host_model

// File: dv/cim_top_tb_top.sv
// self-checking bench of the charger interrupt mask registers
// assumes: inputs change at falling edges, outputs one cycle behind
`timescale 1ns/10ps
module cim_top_tb_top;
    logic mclk = 1'b0;
    logic reset_n, one_shot, rvalid, irq, wr, rd, ce;
    logic [2:0] ctl; // flag clear, watchdog, register reset
    logic [19:0] ev, flags;
    logic [7:0] addr, wdata, rdata, chg_m, therm_m, fault_m;
    int err_count = 0;
    int cmp_count = 0;
    // row: register offset in the top byte, mask bit position below
    logic [15:0] rows [20] = '{16'h2a00, 16'h2a01, 16'h2a02, 16'h2a03, 16'h2a04, 16'h2a05, 16'h2a06,
        16'h2b00, 16'h2b01, 16'h2b02, 16'h2b03, 16'h2b04, 16'h2c00, 16'h2c01, 16'h2c02, 16'h2c03,
        16'h2c04, 16'h2c05, 16'h2c06, 16'h2c07};

    always #5 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////
    cim_top i_cim_top (.i_mclk(mclk), .i_reset_n(reset_n), .i_ce(ce), .i_addr(addr), .i_wr(wr),
        .i_rd(rd), .i_wdata(wdata), .i_reg_rst(ctl[0]), .i_wdog_expire(ctl[1]), .i_flag_clr(ctl[2]),
        .i_src_detect_done(ev[6]), .i_adc_done(ev[5]), .i_adc_one_shot(one_shot),
        .i_min_sys_change(ev[4]), .i_fast_tmr_expire(ev[3]), .i_trickle_tmr_expire(ev[2]),
        .i_pre_tmr_expire(ev[1]), .i_topoff_tmr_expire(ev[0]), .i_bat_low_boost(ev[11]),
        .i_therm_cold(ev[10]), .i_therm_cool(ev[9]), .i_therm_warm(ev[8]), .i_therm_hot(ev[7]),
        .i_bat_cur_reg_change(ev[19]), .i_bus_ovp(ev[18]), .i_bat_ovp(ev[17]), .i_input_ocp(ev[16]),
        .i_bat_ocp(ev[15]), .i_switch_ocp(ev[14]), .i_adapter_b_ovp(ev[13]), .i_adapter_a_ovp(ev[12]),
        .o_rdata(rdata), .o_rvalid(rvalid), .o_event_flags(flags), .o_irq_pulse(irq),
        .o_chg_mask(chg_m), .o_therm_mask(therm_m), .o_fault_mask(fault_m));

    cim_host_model i_cim_host_model (.i_mclk(mclk), .i_rvalid(rvalid), .i_rdata(rdata), .o_wr(wr),
        .o_rd(rd), .o_addr(addr), .o_wdata(wdata));

    ////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [19:0] seen, input logic [19:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        i_cim_host_model.rd(a, d, v);
        chk("rvalid", {19'h0, v}, 20'h1);
        chk("rdata", {12'h0, d}, {12'h0, exp});
    endtask : rdchk

    // one-cycle event; pulse and flag are looked at one cycle later
    task automatic fire(input int idx, input logic exp_irq);
        ev[idx] = 1'b1;
        @(negedge mclk);
        ev = 20'h0;
        chk("irq", {19'h0, irq}, {19'h0, exp_irq});
        chk("flag", {19'h0, flags[idx]}, 20'h1);
    endtask : fire

    task automatic cmd(input logic [2:0] c);
        ctl = c;
        @(negedge mclk);
        ctl = 3'b000;
    endtask : cmd

    task automatic results();
        if (err_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #200us;
        err_count++;
        results();
    end

    initial begin
        ev = 20'h0;
        ctl = 3'b000;
        one_shot = 1'b1;
        ce = 1'b1;
        reset_n = 1'b0;
        repeat (5) @(negedge mclk);
        reset_n = 1'b1;
        @(negedge mclk);
        for (int i = 0; i < 3; i++) rdchk(8'(8'h2a + i), 8'h00);
        // every event: unmasked pulses, masked only flags, register reset clears
        foreach (rows[i]) begin
            cmd(3'b100);
            fire(i, 1'b1);
            i_cim_host_model.wr(rows[i][15:8], 8'h01 << rows[i][2:0]);
            rdchk(rows[i][15:8], 8'h01 << rows[i][2:0]);
            cmd(3'b100);
            fire(i, 1'b0);
            cmd(3'b001);
            rdchk(rows[i][15:8], 8'h00);
        end
        // converter done outside single-conversion mode raises nothing
        one_shot = 1'b0;
        ev[5] = 1'b1;
        @(negedge mclk);
        ev = 20'h0;
        chk("adc irq", {19'h0, irq}, 20'h0);
        one_shot = 1'b1;
        for (int i = 0; i < 3; i++) i_cim_host_model.wr(8'(8'h2a + i), 8'hff);
        chk("chg mirror", {12'h0, chg_m}, 20'h7f);
        chk("therm mirror", {12'h0, therm_m}, 20'h1f);
        chk("fault mirror", {12'h0, fault_m}, 20'hff);
        rdchk(8'h2a, 8'h7f);
        rdchk(8'h2b, 8'h1f);
        rdchk(8'h2c, 8'hff);
        cmd(3'b010);
        rdchk(8'h2a, 8'h7f);
        rdchk(8'h2b, 8'h00);
        chk("therm mirror clr", {12'h0, therm_m}, 20'h0);
        rdchk(8'h2c, 8'hff);
        rdchk(8'h2d, 8'h00);
        // frozen clock enable: write and open event both ignored
        ce = 1'b0;
        i_cim_host_model.wr(8'h2c, 8'h00);
        ev[7] = 1'b1;
        @(negedge mclk);
        ev = 20'h0;
        chk("frozen irq", {19'h0, irq}, 20'h0);
        chk("frozen flag", {19'h0, flags[7]}, 20'h0);
        ce = 1'b1;
        rdchk(8'h2c, 8'hff);
        // masked and unmasked event in one cycle still pulse
        ev[7] = 1'b1;
        ev[18] = 1'b1;
        @(negedge mclk);
        ev = 20'h0;
        chk("mixed irq", {19'h0, irq}, 20'h1);
        chk("mixed flag", {19'h0, flags[18]}, 20'h1);
        // clear and event in one cycle: the event's flag survives, others go
        @(negedge mclk);
        ctl = 3'b100;
        ev[18] = 1'b1;
        @(negedge mclk);
        ctl = 3'b000;
        ev = 20'h0;
        chk("race flag", {19'h0, flags[18]}, 20'h1);
        chk("cleared flag", {19'h0, flags[7]}, 20'h0);
        chk("race irq", {19'h0, irq}, 20'h0);
        // second reset in mid-run
        reset_n = 1'b0;
        @(negedge mclk);
        reset_n = 1'b1;
        @(negedge mclk);
        chk("flags after reset", flags, 20'h0);
        chk("fault mirror rst", {12'h0, fault_m}, 20'h0);
        rdchk(8'h2a, 8'h00);
        rdchk(8'h2c, 8'h00);
        results();
    end
endmodule : cim_top_tb_top
